/* File: verilog/tdc_pkg.sv */
// Shared constants for the transceiver datapath clock distribution block
package tdc_pkg;
    // Channels in one transceiver block
    localparam int NCH = 4;
    // Phase compensation FIFO pointer width (four words deep)
    localparam int PTR_W = 2;
    // Default serial-to-parallel factor of the recovered clock divider
    localparam int DESER_DEFAULT = 10;
    // Width of the recovered clock divider counter
    localparam int DIV_W = 4;

    // Bonding codes on the cfg_bond port
    localparam logic [1:0] BOND_X1 = 2'h0;
    localparam logic [1:0] BOND_X2 = 2'h1;
    localparam logic [1:0] BOND_X4 = 2'h2;

    // Operation codes on the cfg_op port
    localparam logic [1:0] OP_TX   = 2'h0;
    localparam logic [1:0] OP_RX   = 2'h1;
    localparam logic [1:0] OP_TXRX = 2'h2;

    // Channels that form the two-channel bonded pair
    localparam logic [3:0] X2_MEMBERS = 4'h3;
    // Channels that form the four-channel bonded group
    localparam logic [3:0] X4_MEMBERS = 4'hf;

    // Configuration life cycle
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_RUN,
        MODE_FAULT
    } tdc_mode_type;
endpackage

/* File: verilog/tdc_rec_div.sv */
// Recovered clock divider: low-speed and halved low-speed ticks
`timescale 1ns/1ps
module tdc_rec_div #(
    parameter int CNT_W = tdc_pkg::DIV_W,
    parameter int DIV   = tdc_pkg::DESER_DEFAULT
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic clr,
    input  wire logic hs_tick,
    output logic      ls_tick,
    output logic      ls_half_tick
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             half;
    } tdc_div_state_type;

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV - 1);

    tdc_div_state_type st_reg;
    tdc_div_state_type st_next;

    // Tick outputs decoded from the current count
    assign ls_tick      = hs_tick && (st_reg.cnt == CNT_LAST);
    assign ls_half_tick = ls_tick && st_reg.half;

    // Count high-speed ticks, toggle phase on each low-speed tick
    always_comb begin
        st_next = st_reg;
        if (clr) begin
            st_next.cnt  = '0;
            st_next.half = 1'b0;
        end else if (hs_tick) begin
            if (st_reg.cnt == CNT_LAST) begin
                st_next.cnt  = '0;
                st_next.half = ~st_reg.half;
            end else begin
                st_next.cnt = st_reg.cnt + CNT_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Divider never exceeds its terminal count
    a_div_count_range: assert property (@(posedge mclk) disable iff (!rstn)
        st_reg.cnt <= CNT_LAST) else $error("divider count out of range");
endmodule

/* File: verilog/tdc_clock_dist.sv */
// Operation
// - Receiver clock recovery takes clocks from one of two adjacent PLLs.
// - No receiver clock recovery source beyond the two adjacent PLLs.
// - All receivers of one block share a single recovery PLL.
// - Fast clock to serializer; slow clock to tx PCS, rx PCS with rate match.
// - Non-bonded channels pick own low-speed clock and FIFO pointers.
// - Bonded channels share one low-speed path and common FIFO pointers; the rx side shares them only with rate match.
// - Two-channel bonding uses channels 0 and 1 only.
// - Four-channel bonding covers all four channels.
// - Non-bonded clocks come from one of the two adjacent PLLs.
// - Transmit-only selects PLL clocks; high-speed clock feeds serializer.
// - Tx low-speed clock drives encoder, serializer read, tx FIFO read.
// - Byte serializer on halves the tx FIFO read clock.
// - Tx low-speed clock exported; fabric sends tx data with it.
// - Receive-only has no rate match; recovery makes high and low clocks.
// - No rate match: recovered clock to aligner, decoder, ordering, writes.
// - Byte deserializer on halves the rx FIFO write clock.
// - Recovered low-speed clock exported; fabric captures rx data with it.
// - Combined mode allows both rate match choices, reusing one-way clocking.
// - With rate match, tx low-speed clock drives rx PCS after rate match.
// - Bonding not offered for receive-only operation.
`timescale 1ns/1ps
module tdc_clock_dist #(
    parameter int DESER = tdc_pkg::DESER_DEFAULT
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       pll_a_cdr_tick,
    input  wire logic       pll_b_cdr_tick,
    input  wire logic       pll_a_hs_tick,
    input  wire logic       pll_b_hs_tick,
    input  wire logic       pll_a_ls_tick,
    input  wire logic       pll_b_ls_tick,
    input  wire logic [3:0] chan_run,
    input  wire logic [1:0] cfg_bond,
    input  wire logic [1:0] cfg_op,
    input  wire logic       cfg_rate_match,
    input  wire logic       cfg_byte_ser,
    input  wire logic       cfg_byte_deser,
    input  wire logic       cfg_cdr_sel,
    input  wire logic [3:0] cfg_chan_sel,
    input  wire logic       cfg_bond_sel,
    output logic [3:0]      tx_ser_en,
    output logic [3:0]      tx_enc_en,
    output logic [3:0]      tx_bser_rd_en,
    output logic [3:0]      tx_pcf_rd_en,
    output logic [3:0]      tx_clkout_en,
    output logic [3:0]      rx_deser_en,
    output logic [3:0]      rx_align_en,
    output logic [3:0]      rx_rm_wr_en,
    output logic [3:0]      rx_rm_rd_en,
    output logic [3:0]      rx_dec_en,
    output logic [3:0]      rx_bdes_wr_en,
    output logic [3:0]      rx_bord_en,
    output logic [3:0]      rx_pcf_wr_en,
    output logic [3:0]      rx_clkout_en,
    output logic            bond_clkout_en,
    output logic [7:0]      tx_pcf_rd_ptr,
    output logic [7:0]      rx_pcf_wr_ptr,
    output logic            cfg_locked,
    output logic            cfg_err
);
    localparam int NCH = tdc_pkg::NCH;
    localparam int PW  = tdc_pkg::PTR_W;

    typedef struct packed {
        tdc_pkg::tdc_mode_type mode;
        logic [1:0]            bond, op;
        logic                  rm, bser, bdes, cdr_sel, bond_sel;
        logic [3:0]            ch_sel;
        logic                  err;
        logic [3:0]            tx_half;
        logic                  bond_half;
        logic [PW-1:0]         bond_tx_ptr, bond_rx_ptr;
        logic [7:0]            tx_ptr, rx_ptr;
        logic [3:0]            tx_ser, tx_enc, tx_pcf, rx_deser, rx_align;
        logic [3:0]            rx_rm_wr, rx_rm_rd, rx_pcs, rx_pcf;
        logic                  bond_clk;
    } tdc_state_type;

    tdc_state_type st_reg;
    tdc_state_type st_next;
    logic [3:0]    rec_ls, rec_ls_half, rec_clr, rec_hs;
    logic          cdr_pick;

    // Channel membership in the active bonded group
    function automatic logic in_bond(input int ch, input logic [1:0] bond);
        logic [3:0] grp;
        grp = 4'h0;
        if (bond == tdc_pkg::BOND_X2) begin
            grp = tdc_pkg::X2_MEMBERS;
        end else if (bond == tdc_pkg::BOND_X4) begin
            grp = tdc_pkg::X4_MEMBERS;
        end
        return grp[ch];
    endfunction

    // Configuration legality check
    function automatic logic bad_cfg(input logic [1:0] bond,
                                     input logic [1:0] op,
                                     input logic       rm);
        logic bad;
        bad = (op != tdc_pkg::OP_TX) && (op != tdc_pkg::OP_RX)
              && (op != tdc_pkg::OP_TXRX);
        bad = bad || ((bond != tdc_pkg::BOND_X1)
              && (bond != tdc_pkg::BOND_X2)
              && (bond != tdc_pkg::BOND_X4));
        bad = bad || (op == tdc_pkg::OP_RX && bond != tdc_pkg::BOND_X1);
        // receive only runs without rate match
        bad = bad || (op == tdc_pkg::OP_RX && rm);
        return bad;
    endfunction

    // one adjacent recovery source for the block
    assign cdr_pick = st_reg.cdr_sel ? pll_b_cdr_tick : pll_a_cdr_tick;

    // Per-channel recovered clock dividers
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_rec
            assign rec_clr[g] = (st_reg.mode != tdc_pkg::MODE_RUN)
                                || !chan_run[g]
                                || (st_reg.op == tdc_pkg::OP_TX);
            assign rec_hs[g]  = cdr_pick && !rec_clr[g];
            tdc_rec_div #(
                .CNT_W (tdc_pkg::DIV_W),
                .DIV   (DESER)
            ) u_div (
                .mclk         (mclk),
                .rstn         (rstn),
                .clr          (rec_clr[g]),
                .hs_tick      (rec_hs[g]),
                .ls_tick      (rec_ls[g]),
                .ls_half_tick (rec_ls_half[g])
            );
        end
    endgenerate

    // Next state: config capture, clock steering, FIFO pointers
    always_comb begin
        logic          run, bnd, tx_act, rx_act, hs, ls, ls_bond, h;
        logic          ls_div2, pcs, pcs_half, bond_rd, bond_wr;
        logic [PW-1:0] p;
        bnd      = 1'b0;
        tx_act   = 1'b0;
        rx_act   = 1'b0;
        hs       = 1'b0;
        ls       = 1'b0;
        h        = 1'b0;
        ls_div2  = 1'b0;
        pcs      = 1'b0;
        pcs_half = 1'b0;
        p        = '0;
        st_next  = st_reg;
        run      = (st_reg.mode == tdc_pkg::MODE_RUN);
        // one low-speed path for every bonded channel
        ls_bond  = st_reg.bond_sel ? pll_b_ls_tick : pll_a_ls_tick;
        bond_rd  = ls_bond && (!st_reg.bser || st_reg.bond_half);
        // Shared write pointer follows the rx halving choice
        bond_wr  = st_reg.rm && ls_bond
                   && (!st_reg.bdes || st_reg.bond_half);
        {st_next.tx_ser, st_next.tx_enc, st_next.tx_pcf, st_next.rx_deser,
         st_next.rx_align, st_next.rx_rm_wr, st_next.rx_rm_rd,
         st_next.rx_pcs, st_next.rx_pcf} = '0;
        st_next.bond_clk = run && st_reg.bond != tdc_pkg::BOND_X1
                           && st_reg.op != tdc_pkg::OP_RX && ls_bond;
        unique case (st_reg.mode)
            tdc_pkg::MODE_IDLE: begin
                // selections follow the ports only while idle
                st_next.bond     = cfg_bond;
                st_next.op       = cfg_op;
                st_next.rm       = cfg_rate_match;
                st_next.bser     = cfg_byte_ser;
                st_next.bdes     = cfg_byte_deser;
                st_next.cdr_sel  = cfg_cdr_sel;
                st_next.bond_sel = cfg_bond_sel;
                st_next.ch_sel   = cfg_chan_sel;
                st_next.err      = bad_cfg(st_reg.bond, st_reg.op, st_reg.rm);
                {st_next.tx_half, st_next.bond_half, st_next.bond_tx_ptr,
                 st_next.bond_rx_ptr, st_next.tx_ptr, st_next.rx_ptr} = '0;
                if (|chan_run) begin
                    st_next.mode = st_next.err ? tdc_pkg::MODE_FAULT
                                               : tdc_pkg::MODE_RUN;
                end
            end
            tdc_pkg::MODE_RUN: begin
                st_next.bond_half = st_reg.bond_half ^ ls_bond;
                if (bond_rd) begin
                    st_next.bond_tx_ptr = st_reg.bond_tx_ptr + PW'(1);
                end
                if (bond_wr) begin
                    st_next.bond_rx_ptr = st_reg.bond_rx_ptr + PW'(1);
                end
                for (int i = 0; i < NCH; i++) begin
                    // pair 0/1 only; all four channels
                    bnd    = in_bond(i, st_reg.bond);
                    tx_act = chan_run[i] && st_reg.op != tdc_pkg::OP_RX;
                    rx_act = chan_run[i] && st_reg.op != tdc_pkg::OP_TX;
                    // own PLL choice among the adjacent pair
                    hs = st_reg.ch_sel[i] ? pll_b_hs_tick : pll_a_hs_tick;
                    // independent low-speed source when not bonded
                    ls = st_reg.ch_sel[i] ? pll_b_ls_tick : pll_a_ls_tick;
                    if (bnd) begin
                        ls = ls_bond;
                        h  = st_reg.bond_half;
                    end else begin
                        h  = st_reg.tx_half[i];
                    end
                    st_next.tx_half[i] = st_reg.tx_half[i] ^ ls;
                    // halved read clock with byte serializer
                    ls_div2 = ls && h;
                    st_next.tx_ser[i] = tx_act && hs;
                    st_next.tx_enc[i] = tx_act && ls;
                    st_next.tx_pcf[i] = tx_act
                                        && (st_reg.bser ? ls_div2 : ls);
                    st_next.rx_deser[i] = rx_act && cdr_pick;
                    // aligner always on recovered low-speed clock
                    st_next.rx_align[i] = rx_act && rec_ls[i];
                    // rate match write recovered, read transmit side
                    st_next.rx_rm_wr[i] = rx_act && st_reg.rm && rec_ls[i];
                    // rx PCS on low-speed clock only with rate match
                    st_next.rx_rm_rd[i] = rx_act && st_reg.rm && ls;
                    // choose rx PCS clock by rate match setting
                    pcs      = st_reg.rm ? ls : rec_ls[i];
                    pcs_half = st_reg.rm ? ls_div2 : rec_ls_half[i];
                    st_next.rx_pcs[i] = rx_act && pcs;
                    // halved write clock with byte deserializer
                    st_next.rx_pcf[i] = rx_act
                                        && (st_reg.bdes ? pcs_half : pcs);
                    // bonded tx pointers follow the common counter; bonded rx pointers only with rate match
                    if (bnd) begin
                        st_next.tx_ptr[i*PW +: PW] = st_next.bond_tx_ptr;
                    end else if (st_next.tx_pcf[i]) begin
                        p = st_reg.tx_ptr[i*PW +: PW];
                        st_next.tx_ptr[i*PW +: PW] = p + PW'(1);
                    end
                    if (bnd && st_reg.rm) begin
                        st_next.rx_ptr[i*PW +: PW] = st_next.bond_rx_ptr;
                    end else if (st_next.rx_pcf[i]) begin
                        p = st_reg.rx_ptr[i*PW +: PW];
                        st_next.rx_ptr[i*PW +: PW] = p + PW'(1);
                    end
                end
                if (!(|chan_run)) begin
                    st_next.mode = tdc_pkg::MODE_IDLE;
                end
            end
            tdc_pkg::MODE_FAULT: begin
                if (!(|chan_run)) begin
                    st_next.mode = tdc_pkg::MODE_IDLE;
                end
            end
            default: begin
                st_next.mode = tdc_pkg::MODE_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Registered enables and status to the ports
    assign tx_ser_en      = st_reg.tx_ser;
    assign tx_enc_en      = st_reg.tx_enc;
    assign tx_bser_rd_en  = st_reg.tx_enc;
    assign tx_pcf_rd_en   = st_reg.tx_pcf;
    // transmit low-speed clock exported to fabric
    assign tx_clkout_en   = st_reg.tx_enc;
    assign rx_deser_en    = st_reg.rx_deser;
    assign rx_align_en    = st_reg.rx_align;
    assign rx_rm_wr_en    = st_reg.rx_rm_wr;
    assign rx_rm_rd_en    = st_reg.rx_rm_rd;
    assign rx_dec_en      = st_reg.rx_pcs;
    assign rx_bdes_wr_en  = st_reg.rx_pcs;
    assign rx_bord_en     = st_reg.rx_pcs;
    assign rx_pcf_wr_en   = st_reg.rx_pcf;
    // receive capture clock exported to fabric
    assign rx_clkout_en   = st_reg.rx_pcs;
    assign bond_clkout_en = st_reg.bond_clk;
    assign tx_pcf_rd_ptr  = st_reg.tx_ptr;
    assign rx_pcf_wr_ptr  = st_reg.rx_ptr;
    assign cfg_locked     = (st_reg.mode != tdc_pkg::MODE_IDLE);
    assign cfg_err        = st_reg.err;

    // Checks on the distribution
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_cdr_source_one: assert property (rx_deser_en[0] |->
        $past(cdr_pick))
        else $error("deserializer tick without selected recovery tick");
    a_no_foreign_pll: assert property ((|rx_deser_en) |->
        $past(pll_a_cdr_tick) || $past(pll_b_cdr_tick))
        else $error("recovery tick from no adjacent pll");
    a_rm_read_gate: assert property ((|rx_rm_rd_en) |-> st_reg.rm)
        else $error("rate match read clock without rate match");
    a_x4_ptr_equal: assert property ((st_reg.mode == tdc_pkg::MODE_RUN
        && st_reg.bond == tdc_pkg::BOND_X4) ##1 (st_reg.mode ==
        tdc_pkg::MODE_RUN) |-> tx_pcf_rd_ptr[1:0] == tx_pcf_rd_ptr[7:6])
        else $error("bonded pointers differ");
    a_x2_pair_equal: assert property ((st_reg.mode == tdc_pkg::MODE_RUN
        && st_reg.bond == tdc_pkg::BOND_X2) ##1 (st_reg.mode ==
        tdc_pkg::MODE_RUN) |-> tx_pcf_rd_ptr[1:0] == tx_pcf_rd_ptr[3:2])
        else $error("pair pointers differ");
    a_rx_no_bond: assert property (st_reg.mode == tdc_pkg::MODE_RUN |->
        !(st_reg.op == tdc_pkg::OP_RX && st_reg.bond != tdc_pkg::BOND_X1))
        else $error("bonded receive only running");
    a_ser_halving: assert property (tx_pcf_rd_en[0] && st_reg.bser
        && $past(tx_enc_en[0]) |-> !$past(tx_pcf_rd_en[0]))
        else $error("tx fifo read not halved");
    a_wr_subset: assert property (rx_pcf_wr_en[1] |-> rx_dec_en[1])
        else $error("rx fifo write outside pcs clock");
    a_cfg_frozen: assert property ((st_reg.mode == tdc_pkg::MODE_RUN)
        ##1 (st_reg.mode == tdc_pkg::MODE_RUN) |->
        $stable(st_reg.op) && $stable(st_reg.ch_sel)
        && $stable(st_reg.bond))
        else $error("clock selection changed while running");

    c_x4_run: cover property (st_reg.mode == tdc_pkg::MODE_RUN
        && st_reg.bond == tdc_pkg::BOND_X4 && tx_pcf_rd_en[3]);
    c_rm_path: cover property (rx_rm_wr_en[0] ##[1:40] rx_rm_rd_en[0]);
    c_deser_half: cover property (st_reg.bdes && rx_pcf_wr_en[2]);
    c_fault: cover property (st_reg.mode == tdc_pkg::MODE_FAULT);
endmodule

/* File: bench/tdc_fabric_model.sv */
// Fabric logic model that sends and captures on the exported clocks
`timescale 1ns/1ps
module tdc_fabric_model (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic       tx_clk_en,
    input  wire logic       rx_clk_en,
    output logic [7:0]      tx_sent,
    output logic [7:0]      rx_taken
);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_sent  <= 8'h0;
            rx_taken <= 8'h0;
        end else if (!run) begin
            tx_sent  <= 8'h0; // Idle fabric holds no words
            rx_taken <= 8'h0;
        end else begin
            tx_sent  <= tx_sent + 8'(tx_clk_en);
            rx_taken <= rx_taken + 8'(rx_clk_en);
        end
    end
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the transceiver clock distribution block
`timescale 1ns/1ps
module tb_top;
    localparam int DESER = 2;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ha = 0, hb = 0, la = 0, lb = 0, ca = 0, cb = 0;
    logic [3:0] chan_run = 4'h0, cfg_chan_sel = 4'h0;
    logic [1:0] cfg_bond = 2'h0, cfg_op = 2'h0;
    logic cfg_rate_match = 0, cfg_byte_ser = 0, cfg_byte_deser = 0;
    logic cfg_cdr_sel = 0, cfg_bond_sel = 0;
    logic [3:0] tx_ser_en, tx_enc_en, tx_bser_rd_en, tx_pcf_rd_en;
    logic [3:0] tx_clkout_en, rx_deser_en, rx_align_en, rx_rm_wr_en;
    logic [3:0] rx_rm_rd_en, rx_dec_en, rx_bdes_wr_en, rx_bord_en;
    logic [3:0] rx_pcf_wr_en, rx_clkout_en, rs, ph, et, el, ep, ed, epc;
    logic [7:0] tx_pcf_rd_ptr, rx_pcf_wr_ptr, fab_tx, fab_rx;
    logic bond_clkout_en, cfg_locked, cfg_err, eb, bon, chk = 0;
    logic [1:0] rb;
    logic rrm, rser, rbs, rc, flt, tx_ok, rx_ok;
    logic [5:0] s;
    int err_total = 0, compares = 0, cyc = 0;
    int n_ls, n_cd, n_al, n_pw, n_pr, p0;

    tdc_clock_dist #(.DESER(DESER)) tdc_clock_dist_inst (
        .mclk, .rstn, .pll_a_cdr_tick(ca), .pll_b_cdr_tick(cb),
        .pll_a_hs_tick(ha), .pll_b_hs_tick(hb), .pll_a_ls_tick(la),
        .pll_b_ls_tick(lb), .chan_run, .cfg_bond, .cfg_op, .cfg_rate_match,
        .cfg_byte_ser, .cfg_byte_deser, .cfg_cdr_sel, .cfg_chan_sel,
        .cfg_bond_sel, .tx_ser_en, .tx_enc_en, .tx_bser_rd_en, .tx_pcf_rd_en,
        .tx_clkout_en, .rx_deser_en, .rx_align_en, .rx_rm_wr_en, .rx_rm_rd_en,
        .rx_dec_en, .rx_bdes_wr_en, .rx_bord_en, .rx_pcf_wr_en, .rx_clkout_en,
        .bond_clkout_en, .tx_pcf_rd_ptr, .rx_pcf_wr_ptr, .cfg_locked, .cfg_err);

    tdc_fabric_model tdc_fabric_model_inst (.mclk, .rstn, .run(chan_run[0]),
        .tx_clk_en(tx_clkout_en[0]), .rx_clk_en(rx_clkout_en[0]),
        .tx_sent(fab_tx), .rx_taken(fab_rx));

    // Clock and cycle limit
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t count %h exp %h", $time, got, exp);
        end
    endtask

    // Expected enables from the ticks taken at the previous edge
    always @(posedge mclk) s <= {ha, hb, la, lb, ca, cb};
    always @(negedge mclk) if (chk) begin
        for (int i = 0; i < 4; i++) begin
            bon = rb == tdc_pkg::BOND_X4 || (rb == tdc_pkg::BOND_X2 && i < 2);
            et[i] = tx_ok & (rs[i] ? s[4] : s[5]);
            el[i] = tx_ok & ((bon ? rbs : rs[i]) ? s[2] : s[3]);
            ep[i] = el[i] & (!rser | ph[i]);
            ph[i] = ph[i] ^ el[i];
            ed[i] = rx_ok & (rc ? s[0] : s[1]);
        end
        eb = tx_ok & (rb != tdc_pkg::BOND_X1) & (rbs ? s[2] : s[3]);
        cmp4(tx_ser_en, et);
        cmp4(tx_enc_en, el);
        cmp4(tx_bser_rd_en, el);
        cmp4(tx_clkout_en, el);
        cmp4(tx_pcf_rd_en, ep);
        cmp4(rx_deser_en, ed);
        cmp4(rx_rm_rd_en, el & {4{rrm}});
        cmp4({3'h0, bond_clkout_en}, {3'h0, eb});
        epc = rrm ? el : rx_align_en;
        cmp4(rx_rm_wr_en, rx_align_en & {4{rrm}});
        cmp4(rx_dec_en, epc);
        cmp4(rx_bdes_wr_en, epc);
        cmp4(rx_bord_en, epc);
        cmp4(rx_clkout_en, epc);
        n_ls += int'(el[0]);
        n_cd += int'(ed[0]);
        n_al += int'(rx_align_en[0]);
        n_pw += int'(rx_pcf_wr_en[0]);
        n_pr += int'(tx_pcf_rd_en[0]);
    end

    // One configured run with random ticks and moving config inputs
    task automatic scn(input logic [1:0] b, input logic [1:0] o,
                       input logic r, input logic bs, input logic bd,
                       input logic bsl);
        @(posedge mclk);
        #1 rb = b;
        rrm = r;
        rser = bs;
        rbs = bsl;
        rs = 4'($urandom);
        rc = 1'($urandom);
        flt = o == 2'h3 || b == 2'h3 || (o == tdc_pkg::OP_RX && (b != 0 || r));
        tx_ok = !flt && o != tdc_pkg::OP_RX;
        rx_ok = !flt && o != tdc_pkg::OP_TX;
        {cfg_bond, cfg_op, cfg_rate_match, cfg_byte_ser} = {b, o, r, bs};
        {cfg_byte_deser, cfg_bond_sel} = {bd, bsl};
        {cfg_chan_sel, cfg_cdr_sel} = {rs, rc};
        repeat (2) @(posedge mclk);
        #1 chan_run = 4'hf;
        repeat (3) @(posedge mclk);
        #1 cmp4({3'h0, cfg_err}, {3'h0, flt});
        {ph, n_ls, n_cd, n_al, n_pw, n_pr} = '0;
        p0 = int'(tx_pcf_rd_ptr[1:0]);
        chk = 1;
        repeat (60) begin
            @(posedge mclk);
            #1 {ha, hb, la, lb, ca, cb} = 6'($urandom);
            {cfg_chan_sel, cfg_cdr_sel} = 5'($urandom);
        end
        @(posedge mclk);
        #1 {ha, hb, la, lb, ca, cb} = 6'h0;
        repeat (3) @(posedge mclk);
        #1 chk = 0;
        cmp8(8'(n_al), 8'(n_cd / DESER));
        if (!r) cmp8(8'(n_pw), 8'(bd ? n_al / 2 : n_al));
        if (!r) cmp8(fab_rx, 8'(n_al));
        cmp8(fab_tx, 8'(n_ls));
        cmp8({6'h0, tx_pcf_rd_ptr[1:0]}, 8'((p0 + n_pr) % 4));
        cmp8({6'h0, rx_pcf_wr_ptr[1:0]}, 8'(n_pw % 4));
        if (tx_ok && b != 0)
            cmp4(tx_pcf_rd_ptr[3:0], {2{tx_pcf_rd_ptr[1:0]}});
        if (tx_ok && b == tdc_pkg::BOND_X4)
            cmp8(tx_pcf_rd_ptr, {4{tx_pcf_rd_ptr[1:0]}});
        cmp4({3'h0, cfg_locked}, 4'h1);
        chan_run = 4'h0;
        repeat (2) @(posedge mclk);
        #1 cmp4({3'h0, cfg_locked}, 4'h0);
    endtask

    task automatic wrap_up();
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Reset, corner configurations, then random legal ones
    initial begin
        logic [1:0] o;
        void'($urandom(45));
        repeat (5) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (2) @(posedge mclk);
        #1 cmp4(tx_ser_en | rx_deser_en, 4'h0);
        scn(tdc_pkg::BOND_X1, tdc_pkg::OP_TX, 0, 1, 0, 0);
        scn(tdc_pkg::BOND_X1, tdc_pkg::OP_RX, 0, 0, 1, 0);
        scn(tdc_pkg::BOND_X1, tdc_pkg::OP_TXRX, 1, 0, 1, 1);
        scn(tdc_pkg::BOND_X2, tdc_pkg::OP_TXRX, 0, 1, 1, 1);
        scn(tdc_pkg::BOND_X4, tdc_pkg::OP_TX, 0, 1, 0, 0);
        scn(tdc_pkg::BOND_X2, tdc_pkg::OP_RX, 0, 0, 0, 0);
        scn(tdc_pkg::BOND_X1, tdc_pkg::OP_RX, 1, 0, 0, 0);
        scn(tdc_pkg::BOND_X1, 2'h3, 0, 0, 0, 0);
        scn(2'h3, tdc_pkg::OP_TX, 0, 0, 0, 0);
        repeat (6) begin
            o = 2'($urandom % 3);
            scn(o == tdc_pkg::OP_RX ? 2'h0 : 2'($urandom % 3), o,
                o == tdc_pkg::OP_TXRX && 1'($urandom), 1'($urandom),
                1'($urandom), 1'($urandom));
        end
        wrap_up();
    end
endmodule
